// [hw/rx_pkg.sv]
package rx_pkg;

  // Oversampling per bit and the first voting sample for each receive mode
  localparam logic [4:0] SAMP_NORMAL       = 5'h10;
  localparam logic [4:0] SAMP_DOUBLE       = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] SAMPLE_ONE        = 5'h01;

  // receive_sampling_mode encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DOUBLE = 2'h1;

  // Character size limits
  localparam logic [3:0] CHAR_MIN = 4'h5;
  localparam logic [3:0] CHAR_MAX = 4'h8;

  // SPI host frame: eight data bits, last bit index
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;

  // Receive buffer entry layout
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ENTRY_W  = 11;
  localparam int unsigned POS_OVF  = 8;
  localparam int unsigned POS_PARITY_MISMATCH_FLAG = 9;
  localparam int unsigned POS_STOP_BIT_ERROR_FLAG = 10;
  localparam int unsigned FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP,
    SPI_SHIFT
  } rx_state_e;

endpackage

// [hw/fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface fifo_if #(
  parameter int unsigned WIDTH = 8
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  logic             flush;

  modport producer (output in_valid, output in_data, output flush, input in_ready);
  modport buffer   (input in_valid, input in_data, input flush, output in_ready,
                    output out_valid, output out_data, input out_ready);
  modport consumer (input out_valid, input out_data, output out_ready);
endinterface

`default_nettype wire

// [hw/rx_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module rx_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  fifo_if.buffer    f
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("rx_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              full   = (count_reg == (AW+1)'(DEPTH));
  wire              empty  = (count_reg == '0);
  wire              do_wr  = f.in_valid & ~full;
  wire              do_rd  = f.out_ready & ~empty;

  assign f.in_ready  = ~full;
  assign f.out_valid = ~empty;
  assign f.out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_i)
  begin
    if (do_wr)
      mem_reg[wr_ptr_reg] <= f.in_data;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || f.flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + AW'(do_wr);
      rd_ptr_reg <= rd_ptr_reg + AW'(do_rd);
      count_reg  <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

`default_nettype wire

// [hw/usart_rx_recovery.sv]
`timescale 1ns/1ps
`default_nettype none

module usart_rx_recovery #(
  parameter int unsigned DIV_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             rx_enable_i,
  input  wire logic [1:0]       receive_sampling_mode_i,
  input  wire logic             spi_host_i,
  input  wire logic [DIV_W-1:0] baud_div_i,
  input  wire logic [3:0]       char_bits_i,
  input  wire logic             parity_en_i,
  input  wire logic             parity_odd_i,
  input  wire logic             bit_order_select_i,
  input  wire logic             rx_pin_i,
  output logic                  tx_pin_o,
  output logic                  transfer_clock_pin_o,
  input  wire logic [7:0]       tx_data_i,
  input  wire logic             tx_valid_i,
  output logic                  tx_ready_o,
  output logic                  tx_done_o,
  output logic                  rx_valid_o,
  input  wire logic             rx_ready_i,
  output logic [7:0]            rx_data_o,
  output logic                  stop_bit_error_flag_o,
  output logic                  parity_mismatch_flag_o,
  output logic                  receive_overrun_flag_o
);
  if (DIV_W < 1 || DIV_W > 24)
  begin : g_chk
    $error("usart_rx_recovery DIV_W out of range");
  end

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Input synchroniser: change taken once second and third stages agree
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic line_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      line_reg  <= 1'b1;
    end
    else
    begin
      sync1_reg <= rx_pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg)
        line_reg <= sync3_reg;
    end
  end

  // Oversampling tick; in SPI host mode it is the half clock period
  logic [DIV_W-1:0] div_cnt_reg;
  wire              tick = (div_cnt_reg == baud_div_i);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || tick || !rx_enable_i)
      div_cnt_reg <= '0;
    else
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
  end

  fifo_if #(.WIDTH(rx_pkg::ENTRY_W)) fq ();

  rx_fifo #(
    .WIDTH (rx_pkg::ENTRY_W),
    .DEPTH (rx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .f      (fq.buffer)
  );

  // Mode decode
  wire             dbl        = (receive_sampling_mode_i == rx_pkg::MODE_DOUBLE) & ~spi_host_i;
  wire [4:0]       samp_bit   = dbl ? rx_pkg::SAMP_DOUBLE : rx_pkg::SAMP_NORMAL;
  wire [4:0]       vote_first = dbl ? rx_pkg::VOTE_FIRST_DOUBLE : rx_pkg::VOTE_FIRST_NORMAL;
  wire [4:0]       vote_last  = vote_first + 5'h02;
  wire [3:0]       char_len   = (char_bits_i < rx_pkg::CHAR_MIN) ? rx_pkg::CHAR_MIN :
                                (char_bits_i > rx_pkg::CHAR_MAX) ? rx_pkg::CHAR_MAX : char_bits_i;
  wire [2:0]       last_bit   = 3'(char_len - 4'h1);

  rx_pkg::rx_state_e state_reg;
  rx_pkg::rx_state_e state_next;
  logic [4:0]  samp_reg;
  logic [4:0]  samp_next;
  logic [2:0]  bit_reg;
  logic [2:0]  bit_next;
  logic [1:0]  vote_reg;
  logic [1:0]  vote_next;
  logic        prev_reg;
  logic [7:0]  data_reg;
  logic [7:0]  data_next;
  logic [7:0]  tx_sh_reg;
  logic [7:0]  tx_sh_next;
  logic        par_err_reg;
  logic        par_err_next;
  logic        ovf_pend_reg;
  logic        ovf_pend_next;
  logic        txd_reg;
  logic        txd_next;
  logic        sck_reg;
  logic        sck_next;
  logic        done_reg;
  logic        done_next;
  logic        push;
  logic        push_stop_bit_error_flag;

  // Vote samples 1 and 2 are held, sample 3 is the live line
  wire in_vote   = (samp_reg >= vote_first) && (samp_reg <= vote_last);
  wire at_vote   = (samp_reg == vote_last);
  wire vote_bit  = maj3({vote_reg, line_reg});
  wire bit_end   = (samp_reg == samp_bit);
  wire spi_start = spi_host_i & tx_valid_i & fq.in_ready & (state_reg == rx_pkg::RX_IDLE);
  wire lsb_first = bit_order_select_i;
  wire rx_in_bit = line_reg;

  // SPI transmit and done pulses come from the host shift state, not the plain receive-complete path
  assign tx_ready_o = rx_enable_i & spi_host_i & fq.in_ready &
                      (state_reg == rx_pkg::RX_IDLE);
  assign tx_done_o  = done_reg;
  assign tx_pin_o   = txd_reg;
  assign transfer_clock_pin_o = sck_reg;

  // Frame errors are blanked in SPI host mode; the entry carries its own flags
  assign fq.in_valid = push;
  assign fq.in_data  = {push_stop_bit_error_flag & ~spi_host_i, par_err_reg & ~spi_host_i,
                        ovf_pend_reg & ~spi_host_i, data_reg};
  assign fq.flush    = ~rx_enable_i;
  assign fq.out_ready = rx_ready_i;
  assign rx_valid_o  = fq.out_valid;
  assign rx_data_o   = fq.out_data[rx_pkg::DATA_W-1:0];
  assign stop_bit_error_flag_o  = fq.out_data[rx_pkg::POS_STOP_BIT_ERROR_FLAG];
  assign parity_mismatch_flag_o = fq.out_data[rx_pkg::POS_PARITY_MISMATCH_FLAG];
  assign receive_overrun_flag_o = fq.out_data[rx_pkg::POS_OVF];

  always_comb
  begin
    state_next    = state_reg;
    samp_next     = samp_reg;
    bit_next      = bit_reg;
    vote_next     = vote_reg;
    data_next     = data_reg;
    tx_sh_next    = tx_sh_reg;
    par_err_next  = par_err_reg;
    ovf_pend_next = ovf_pend_reg;
    txd_next      = txd_reg;
    sck_next      = sck_reg;
    done_next     = 1'b0;
    push          = 1'b0;
    push_stop_bit_error_flag     = 1'b0;
    if (tick && state_reg != rx_pkg::SPI_SHIFT)
    begin
      samp_next = bit_end ? rx_pkg::SAMPLE_ONE : samp_reg + 5'h01;
      if (in_vote)
        vote_next = {vote_reg[0], line_reg};
    end
    unique case (state_reg)
      rx_pkg::RX_IDLE:
      begin
        txd_next = 1'b1;
        sck_next = 1'b0;
        if (spi_start)
        begin
          state_next = rx_pkg::SPI_SHIFT;
          tx_sh_next = tx_data_i;
          txd_next   = lsb_first ? tx_data_i[0] : tx_data_i[7];
          bit_next   = '0;
          data_next  = '0;
          par_err_next = 1'b0;
        end
        else if (tick && !spi_host_i && prev_reg && !line_reg)
        begin
          state_next = rx_pkg::RX_START;
          samp_next  = rx_pkg::SAMPLE_ONE + 5'h01;
          data_next  = '0;
          bit_next   = '0;
          par_err_next = 1'b0;
        end
      end
      rx_pkg::RX_START:
        if (tick && at_vote)
        begin
          if (!vote_bit)
          begin
            state_next = rx_pkg::RX_DATA;
            samp_next  = vote_last + 5'h01;
          end
          else
            state_next = rx_pkg::RX_IDLE;
        end
      rx_pkg::RX_DATA:
        if (tick && at_vote)
        begin
          data_next[bit_reg] = vote_bit;
          if (bit_reg == last_bit)
            state_next = parity_en_i ? rx_pkg::RX_PARITY : rx_pkg::RX_STOP;
          else
            bit_next = bit_reg + 3'h1;
        end
      rx_pkg::RX_PARITY:
        if (tick && at_vote)
        begin
          par_err_next = (^data_reg ^ vote_bit) != parity_odd_i;
          state_next   = rx_pkg::RX_STOP;
        end
      rx_pkg::RX_STOP:
        if (tick && at_vote)
        begin
          // Further stop bits fall into idle and are never looked at
          push       = 1'b1;
          push_stop_bit_error_flag  = ~vote_bit;
          state_next = rx_pkg::RX_IDLE;
        end
      rx_pkg::SPI_SHIFT:
        if (tick)
        begin
          if (!sck_reg)
          begin
            sck_next  = 1'b1; // Leading edge samples host-in
            data_next = lsb_first ? {rx_in_bit, data_reg[7:1]} : {data_reg[6:0], rx_in_bit};
          end
          else
          begin
            sck_next = 1'b0;
            if (bit_reg == rx_pkg::SPI_LAST_BIT)
            begin
              push       = 1'b1;
              done_next  = 1'b1;
              txd_next   = 1'b1;
              state_next = rx_pkg::RX_IDLE;
            end
            else
            begin
              bit_next   = bit_reg + 3'h1;
              tx_sh_next = lsb_first ? {1'b0, tx_sh_reg[7:1]} : {tx_sh_reg[6:0], 1'b0};
              txd_next   = lsb_first ? tx_sh_reg[1] : tx_sh_reg[6];
            end
          end
        end
    endcase
    // Lost frame marks the next stored one; a loss beats the clear
    if (push && !fq.in_ready)
      ovf_pend_next = 1'b1;
    else if (push)
      ovf_pend_next = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || !rx_enable_i)
    begin
      state_reg    <= rx_pkg::RX_IDLE;
      samp_reg     <= rx_pkg::SAMPLE_ONE;
      bit_reg      <= '0;
      vote_reg     <= '0;
      data_reg     <= '0;
      tx_sh_reg    <= '0;
      par_err_reg  <= 1'b0;
      ovf_pend_reg <= 1'b0;
      txd_reg      <= 1'b1;
      sck_reg      <= 1'b0;
      done_reg     <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      samp_reg     <= samp_next;
      bit_reg      <= bit_next;
      vote_reg     <= vote_next;
      data_reg     <= data_next;
      tx_sh_reg    <= tx_sh_next;
      par_err_reg  <= par_err_next;
      ovf_pend_reg <= ovf_pend_next;
      txd_reg      <= txd_next;
      sck_reg      <= sck_next;
      done_reg     <= done_next;
    end
  end

  // Previous oversample, for idle-high to low detection only
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      prev_reg <= 1'b1;
    else if (tick)
      prev_reg <= line_reg;
  end

endmodule

`default_nettype wire

// [sim/far_end.sv]
`timescale 1ns/1ps
`default_nettype none

module far_end (
  input  wire logic clk_i,
  input  wire logic sck_i,
  input  wire logic mosi_i,
  output logic      line_o
);
  logic [7:0] resp_reg;
  logic [7:0] got_reg;

  initial
  begin
    line_o = 1'b1;
    resp_reg = 8'hff;
    got_reg = 8'h00;
  end

  // Bits go out LSB first; index 9 may be shortened to test early restarts
  task automatic send(input logic [19:0] bits, input int n, input int per, input int stop);
    for (int i = 0; i < n; i++)
    begin
      line_o = bits[i];
      repeat ((i == 9) ? stop : per) @(negedge clk_i);
    end
    line_o = 1'b1;
  endtask

  task automatic load(input logic [7:0] b);
    resp_reg = b;
    line_o = b[7];
  endtask

  // Shift on falling so the host's rising-edge sample sees settled data
  always @(posedge sck_i) got_reg = {got_reg[6:0], mosi_i};
  always @(negedge sck_i)
  begin
    resp_reg = {resp_reg[6:0], ~resp_reg[7]};
    line_o = resp_reg[7];
  end
endmodule

`default_nettype wire

// [sim/usart_rx_recovery_chk.sv]
`timescale 1ns/1ps
`default_nettype none

module usart_rx_recovery_chk (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       rx_enable_i,
  input wire logic       spi_host_i,
  input wire logic       tx_valid_i,
  input wire logic       rx_ready_i,
  input wire logic       tx_ready_o,
  input wire logic       tx_done_o,
  input wire logic       tx_pin_o,
  input wire logic       transfer_clock_pin_o,
  input wire logic       rx_valid_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       stop_bit_error_flag_o,
  input wire logic       parity_mismatch_flag_o,
  input wire logic       receive_overrun_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_reset_idle: assert property (disable iff (1'b0)
    !rstn_i |=> tx_pin_o && !transfer_clock_pin_o && !rx_valid_o && !tx_done_o)
    else $error("pins not idle after reset");
  chk_done_pulse: assert property (tx_done_o |=> !tx_done_o)
    else $error("done pulse too long");
  chk_ready_busy: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o [*8])
    else $error("new byte taken while busy");
  chk_ready_mode: assert property (tx_ready_o |-> spi_host_i && rx_enable_i)
    else $error("ready outside host mode");
  chk_spi_flags: assert property ($rose(rx_valid_o) && spi_host_i && $past(spi_host_i)
    |-> !stop_bit_error_flag_o && !parity_mismatch_flag_o && !receive_overrun_flag_o)
    else $error("error flag in host mode");
  chk_mosi_hold: assert property (transfer_clock_pin_o && $past(transfer_clock_pin_o)
    |-> $stable(tx_pin_o))
    else $error("host-out moved while clock high");
  chk_done_push: assert property (tx_done_o |-> ##[0:2] rx_valid_o)
    else $error("host frame not buffered");
  chk_flush_off: assert property (!rx_enable_i |=> !rx_valid_o)
    else $error("buffer kept after disable");
  chk_entry_hold: assert property (rx_valid_o && !rx_ready_i && rx_enable_i
    |=> rx_valid_o && $stable({rx_data_o, stop_bit_error_flag_o, parity_mismatch_flag_o}))
    else $error("buffer head changed without pop");
endmodule

bind usart_rx_recovery usart_rx_recovery_chk chk (.clk_i, .rstn_i, .rx_enable_i, .spi_host_i,
  .tx_valid_i, .rx_ready_i, .tx_ready_o, .tx_done_o, .tx_pin_o, .transfer_clock_pin_o,
  .rx_valid_o, .rx_data_o, .stop_bit_error_flag_o, .parity_mismatch_flag_o,
  .receive_overrun_flag_o);

`default_nettype wire

// [sim/usart_rx_recovery_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module usart_rx_recovery_tb;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        rx_enable_i = 1'b0;
  logic [1:0]  receive_sampling_mode_i = 2'h0;
  logic        spi_host_i = 1'b0;
  logic [15:0] baud_div_i = 16'h0000;
  logic [3:0]  char_bits_i = 4'h8;
  logic        parity_en_i = 1'b0;
  logic        parity_odd_i = 1'b0;
  logic        bit_order_select_i = 1'b0;
  logic [7:0]  tx_data_i = 8'h00;
  logic        tx_valid_i = 1'b0;
  logic        rx_ready_i = 1'b0;
  logic        rx_pin_i;
  logic        tx_pin_o;
  logic        transfer_clock_pin_o;
  logic        tx_ready_o;
  logic        tx_done_o;
  logic        rx_valid_o;
  logic [7:0]  rx_data_o;
  logic        stop_bit_error_flag_o;
  logic        parity_mismatch_flag_o;
  logic        receive_overrun_flag_o;
  int          err_count = 0;
  int          total_checks = 0;
  wire logic [2:0] flags = {stop_bit_error_flag_o, parity_mismatch_flag_o, receive_overrun_flag_o};

  always #2.5 clk_i = ~clk_i;

  usart_rx_recovery uut (.clk_i, .rstn_i, .rx_enable_i, .receive_sampling_mode_i, .spi_host_i,
    .baud_div_i, .char_bits_i, .parity_en_i, .parity_odd_i, .bit_order_select_i, .rx_pin_i,
    .tx_pin_o, .transfer_clock_pin_o, .tx_data_i, .tx_valid_i, .tx_ready_o, .tx_done_o,
    .rx_valid_o, .rx_ready_i, .rx_data_o, .stop_bit_error_flag_o, .parity_mismatch_flag_o,
    .receive_overrun_flag_o);
  far_end far (.clk_i(clk_i), .sck_i(transfer_clock_pin_o), .mosi_i(tx_pin_o), .line_o(rx_pin_i));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // 0: entry ready, 1: byte ready, 2: host frame done
  task automatic wait_sig(input int k);
    int n;
    n = 0;
    while ((k == 0 ? rx_valid_o : k == 1 ? tx_ready_o : tx_done_o) !== 1'b1)
    begin
      @(negedge clk_i);
      n++;
      if (n > 4000)
      begin
        err_count++;
        final_report();
      end
    end
  endtask

  task automatic pop(input logic [7:0] d, input logic [2:0] f);
    wait_sig(0);
    check("data", rx_data_o, d);
    check("flags", {5'h00, flags}, {5'h00, f});
    rx_ready_i = 1'b1;
    @(negedge clk_i);
    rx_ready_i = 1'b0;
    @(negedge clk_i);
  endtask

  function automatic logic [19:0] fr(input logic [7:0] d, input logic s);
    return {10'h3ff, s, d, 1'b0};
  endfunction

  function automatic logic [7:0] rev(input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = b[7-i];
    return r;
  endfunction

  task automatic t_modes();
    receive_sampling_mode_i = 2'h3;
    far.send(fr(8'h5a, 1'b1), 10, 16, 16);
    pop(8'h5a, 3'h0);
    receive_sampling_mode_i = 2'h1;
    far.send(fr(8'hc3, 1'b1), 10, 8, 8);
    pop(8'hc3, 3'h0);
    receive_sampling_mode_i = 2'h0;
    $display("test modes done");
  endtask

  // Eight low samples miss the vote, nine just pass it
  task automatic t_start();
    far.send(20'h00000, 1, 8, 8);
    repeat (200) @(negedge clk_i);
    check("reject", {7'h00, rx_valid_o}, 8'h00);
    far.send(20'h00000, 1, 9, 9);
    pop(8'hff, 3'h0);
    $display("test start done");
  endtask

  task automatic t_frames();
    far.send({1'b1, 8'h33, 1'b0, 1'b1, 8'h81, 1'b0}, 20, 16, 10);
    pop(8'h81, 3'h0);
    pop(8'h33, 3'h0);
    far.send(fr(8'h7e, 1'b0), 10, 16, 16);
    pop(8'h7e, 3'h4);
    $display("test frames done");
  endtask

  task automatic t_parity();
    char_bits_i = 4'h5;
    parity_en_i = 1'b1;
    far.send({12'hfff, 2'h3, 5'h13, 1'b0}, 8, 16, 16);
    pop(8'h13, 3'h0);
    far.send({12'hfff, 2'h2, 5'h13, 1'b0}, 8, 16, 16);
    pop(8'h13, 3'h2);
    parity_odd_i = 1'b1;
    far.send({12'hfff, 2'h2, 5'h13, 1'b0}, 8, 16, 16);
    pop(8'h13, 3'h0);
    parity_en_i = 1'b0;
    char_bits_i = 4'h8;
    $display("test parity done");
  endtask

  task automatic t_overrun();
    for (int i = 0; i < 9; i++)
      far.send(fr(8'h40 + i[7:0], 1'b1), 10, 16, 16);
    for (int i = 0; i < 8; i++)
      pop(8'h40 + i[7:0], 3'h0);
    check("empty", {7'h00, rx_valid_o}, 8'h00);
    far.send(fr(8'h55, 1'b1), 10, 16, 16);
    pop(8'h55, 3'h1);
    far.send(fr(8'h66, 1'b1), 10, 16, 16);
    wait_sig(0);
    rx_enable_i = 1'b0;
    @(negedge clk_i);
    check("flush", {7'h00, rx_valid_o}, 8'h00);
    rx_enable_i = 1'b1;
    $display("test overrun done");
  endtask

  task automatic t_spi();
    for (int o = 0; o < 2; o++)
    begin
      rx_enable_i = 1'b0;
      spi_host_i = 1'b1;
      baud_div_i = 16'h0007;
      bit_order_select_i = o[0];
      @(negedge clk_i);
      rx_enable_i = 1'b1;
      far.load(8'h96);
      tx_data_i = 8'h5c;
      @(negedge clk_i);
      wait_sig(1);
      tx_valid_i = 1'b1;
      @(negedge clk_i);
      tx_valid_i = 1'b0;
      wait_sig(2);
      check("mosi", far.got_reg, o[0] ? rev(8'h5c) : 8'h5c);
      pop(o[0] ? rev(8'h96) : 8'h96, 3'h0);
    end
    far.load(8'hff);
    rx_enable_i = 1'b0;
    spi_host_i = 1'b0;
    baud_div_i = 16'h0000;
    @(negedge clk_i);
    rx_enable_i = 1'b1;
    $display("test spi done");
  endtask

  initial
  begin
    repeat (6) @(negedge clk_i);
    rstn_i = 1'b1;
    rx_enable_i = 1'b1;
    @(negedge clk_i);
    t_modes();
    t_start();
    t_frames();
    t_parity();
    t_overrun();
    t_spi();
    final_report();
  end
endmodule

`default_nettype wire
